/* File: pkg/fdcd_defs.svh */
`ifndef FDCD_DEFS_SVH
`define FDCD_DEFS_SVH

// Register byte offsets on the bus
`define FDCD_ADR_DATA      4'h0
`define FDCD_ADR_STAT      4'h4

// Opcode values and the masks that drop don't-care bits
`define FDCD_OP_SPECIFY    8'h03
`define FDCD_OP_SENSE      8'h04
`define FDCD_OP_SEEK       8'h0F
`define FDCD_OP_RSEEK      8'h8F
`define FDCD_MSK_RSEEK     8'hBF
`define FDCD_OP_CONFIG     8'h13
`define FDCD_OP_DUMP       8'h0E
`define FDCD_OP_RDID       8'h0A
`define FDCD_MSK_RDID      8'hBF
`define FDCD_OP_PERP       8'h12
`define FDCD_OP_LOCK       8'h14
`define FDCD_MSK_LOCK      8'h7F

// Result values and lengths
`define FDCD_ST0_INVALID   8'h80
`define FDCD_LEN_ONE       4'h1
`define FDCD_LEN_RDID      4'h7
`define FDCD_LEN_DUMP      4'hA

// Timing: clock period and step-rate unit, both in ns
`define FDCD_CLK_NS        4
`define FDCD_STEP_UNIT_NS  1000000
`define FDCD_SRT_BASE      32'd16

// Reset value of the fifo disable bit
`define FDCD_RST_FIFO_DISABLE     1'b1

`endif

/* File: pkg/fdcd_pkg.sv */
package fdcd_pkg;

  // Command sequencer states
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PARAM    = 3'b001,
    ST_DISPATCH = 3'b010,
    ST_SEEK     = 3'b011,
    ST_RDID     = 3'b100,
    ST_RESULT   = 3'b101
  } fdcd_state_t;

  // Decoded command classes
  typedef enum logic [3:0] {
    C_SPECIFY = 4'h0,
    C_SENSE   = 4'h1,
    C_SEEK    = 4'h2,
    C_RSEEK   = 4'h3,
    C_CONFIG  = 4'h4,
    C_DUMP    = 4'h5,
    C_RDID    = 4'h6,
    C_PERP    = 4'h7,
    C_LOCK    = 4'h8,
    C_INVALID = 4'h9
  } fdcd_cmd_t;

  // Sector identification field from the data separator
  typedef struct packed {
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] rec;
    logic [7:0] size;
  } fdcd_id_t;

endpackage

/* File: logic/fdcd_cmd_decoder.sv */
`include "fdcd_defs.svh"

// Summary of operation
// - Seek steps head until new cylinder reached
// - Sense drive status returns one drive byte
// - Read ID captures first good ID field
// - Perpendicular opcode takes one parameter byte
// - Unknown opcode returns single 80h status
// - Dump reports SC after format, else END_OF_TRACK_SECTOR
// - Drive select bits stay internal only
module fdcd_cmd_decoder #(
  parameter int unsigned STEP_UNIT_CYC = `FDCD_STEP_UNIT_NS / `FDCD_CLK_NS
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [3:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic [2:0]       drive_sense_i,
  input  fdcd_pkg::fdcd_id_t    id_field_i,
  input  wire logic             id_valid_i,
  input  wire logic             id_crc_ok_i,
  input  wire logic             xfer_done_i,
  input  wire logic             xfer_format_i,
  input  wire logic [7:0]       xfer_count_i,
  output logic                  step_o,
  output logic                  step_dir_o
);

  fdcd_pkg::fdcd_state_t state;       // Sequencer state
  fdcd_pkg::fdcd_cmd_t   cls;         // Class of current command
  logic [7:0]            opcode;      // Current opcode byte
  logic [7:0]            param [0:2]; // Parameter bytes
  logic [1:0]            pidx;        // Next parameter slot
  logic [1:0]            pneed;       // Parameters expected
  logic [7:0]            res [0:9];   // Result bytes
  logic [3:0]            ridx;        // Next result to hand out
  logic [3:0]            rlen;        // Result length
  logic [7:0]            present_cylinder_number [0:3];   // Present cylinder per drive
  logic [7:0]            tgt;         // Seek target cylinder
  logic [1:0]            sdrv;        // Drive being stepped
  logic [23:0]           tmr;         // Step interval timer
  logic [3:0]            step_rate_time;         // Step rate time
  logic [3:0]            head_unload_time;         // Head unload time
  logic [6:0]            head_load_time;         // Head load time
  logic                  nd;          // Non-DMA mode
  logic                  implied_seek_enable;         // Implied seek enable
  logic                  fifo_disable;       // Fifo disable
  logic                  poll;        // Polling disable
  logic [3:0]            thr;         // Fifo threshold
  logic [7:0]            precomp_start_track;      // Precomp start track
  logic [3:0]            perp_drv;    // Per-drive perpendicular enables
  logic [1:0]            perp_gw;     // Gap and write-gate timing
  logic                  lock;        // Lock state
  logic                  last_fmt;    // Last transfer was a format
  logic [7:0]            sc_val;      // Sectors per cylinder of last format
  logic [7:0]            eot_val;     // End of track of last read/write
  logic [2:0]            sense_meta;  // First sync stage, read only by second
  logic [2:0]            sense_sync;  // {ready, track0, write protect}
  logic                  bus_req;
  logic                  wr_data;
  logic                  rd_data;
  logic                  accepting;
  logic [7:0]            cur_pcn;
  logic [7:0]            drive_byte;
  logic [23:0]           step_len;
  fdcd_pkg::fdcd_cmd_t   cls_in;

  // Opcode classifier, used at opcode write
  function automatic fdcd_pkg::fdcd_cmd_t decode(input logic [7:0] op);
    if (op == `FDCD_OP_SPECIFY) return fdcd_pkg::C_SPECIFY;
    if (op == `FDCD_OP_SENSE) return fdcd_pkg::C_SENSE;
    if (op == `FDCD_OP_SEEK) return fdcd_pkg::C_SEEK;
    if ((op & `FDCD_MSK_RSEEK) == `FDCD_OP_RSEEK) return fdcd_pkg::C_RSEEK;
    if (op == `FDCD_OP_CONFIG) return fdcd_pkg::C_CONFIG;
    if (op == `FDCD_OP_DUMP) return fdcd_pkg::C_DUMP;
    if ((op & `FDCD_MSK_RDID) == `FDCD_OP_RDID) return fdcd_pkg::C_RDID;
    if (op == `FDCD_OP_PERP) return fdcd_pkg::C_PERP;
    if ((op & `FDCD_MSK_LOCK) == `FDCD_OP_LOCK) return fdcd_pkg::C_LOCK;
    return fdcd_pkg::C_INVALID;
  endfunction

  // Parameter bytes that follow each opcode
  function automatic logic [1:0] param_count(input fdcd_pkg::fdcd_cmd_t c);
    unique case (c)
      fdcd_pkg::C_SPECIFY, fdcd_pkg::C_SEEK, fdcd_pkg::C_RSEEK: return 2'd2;
      fdcd_pkg::C_SENSE, fdcd_pkg::C_RDID, fdcd_pkg::C_PERP:    return 2'd1;
      fdcd_pkg::C_CONFIG:                                       return 2'd3;
      default:                                                  return 2'd0;
    endcase
  endfunction

  // Bus request qualifiers; a held request is served once
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_data   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `FDCD_ADR_DATA);
  assign rd_data   = bus_req & ~wb_we_i & (wb_adr_i == `FDCD_ADR_DATA)
                   & (state == fdcd_pkg::ST_RESULT);
  assign accepting = (state == fdcd_pkg::ST_IDLE) | (state == fdcd_pkg::ST_PARAM);
  assign cls_in    = decode(wb_dat_i[7:0]);
  assign cur_pcn   = present_cylinder_number[sdrv];
  // Slow rates give long intervals: 16 minus code, in step units
  assign step_len  = 24'((`FDCD_SRT_BASE - 32'(step_rate_time)) * STEP_UNIT_CYC);
  // drive state byte
  // Select bits echoed, never driven out to the drive pins
  assign drive_byte = {1'b0, sense_sync[0], sense_sync[2], sense_sync[1], 1'b1,
                       param[0][2:0]};

  // Drive pins are asynchronous: two flops before use
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          sense_meta[g] <= 1'b0;
          sense_sync[g] <= 1'b0;
        end else begin
          sense_meta[g] <= drive_sense_i[g];
          sense_sync[g] <= sense_meta[g];
        end
      end
    end
  endgenerate

  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i && wb_adr_i == `FDCD_ADR_DATA && state == fdcd_pkg::ST_RESULT) begin
        wb_dat_o[7:0] <= res[ridx];
      end else if (bus_req && !wb_we_i && wb_adr_i == `FDCD_ADR_STAT) begin
        wb_dat_o[2:0] <= {~accepting, state == fdcd_pkg::ST_RESULT, accepting};
      end
    end
  end

  // Command sequencer: opcode, parameters, execution, results
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state  <= fdcd_pkg::ST_IDLE;
      cls    <= fdcd_pkg::C_INVALID;
      opcode <= 8'h00;
      pidx   <= 2'd0;
      pneed  <= 2'd0;
      ridx   <= 4'h0;
      rlen   <= 4'h0;
      for (int i = 0; i < 3; i++) param[i] <= 8'h00;
      for (int i = 0; i < 10; i++) res[i] <= 8'h00;
    end else begin
      unique case (state)
        fdcd_pkg::ST_IDLE: begin
          // Writes outside command phase are dropped
          if (wr_data) begin
            opcode <= wb_dat_i[7:0];
            cls    <= cls_in;
            pidx   <= 2'd0;
            pneed  <= param_count(cls_in);
            state  <= (param_count(cls_in) == 2'd0) ? fdcd_pkg::ST_DISPATCH
                                                    : fdcd_pkg::ST_PARAM;
          end
        end
        fdcd_pkg::ST_PARAM: begin
          if (wr_data) begin
            param[pidx] <= wb_dat_i[7:0];
            pidx        <= pidx + 2'd1;
            if (pidx == pneed - 2'd1) state <= fdcd_pkg::ST_DISPATCH;
          end
        end
        fdcd_pkg::ST_DISPATCH: begin
          ridx <= 4'h0;
          unique case (cls)
            fdcd_pkg::C_SENSE: begin
              res[0] <= drive_byte;
              rlen   <= `FDCD_LEN_ONE;
              state  <= fdcd_pkg::ST_RESULT;
            end
            fdcd_pkg::C_SEEK, fdcd_pkg::C_RSEEK: state <= fdcd_pkg::ST_SEEK;
            fdcd_pkg::C_RDID: state <= fdcd_pkg::ST_RDID;
            fdcd_pkg::C_DUMP: begin
              for (int i = 0; i < 4; i++) res[i] <= present_cylinder_number[i];
              res[4] <= {step_rate_time, head_unload_time};
              res[5] <= {head_load_time, nd};
              // format count or end of track
              res[6] <= last_fmt ? sc_val : eot_val;
              res[7] <= {lock, 1'b0, perp_drv, perp_gw};
              res[8] <= {1'b0, implied_seek_enable, fifo_disable, poll, thr};
              res[9] <= precomp_start_track;
              rlen   <= `FDCD_LEN_DUMP;
              state  <= fdcd_pkg::ST_RESULT;
            end
            fdcd_pkg::C_LOCK: begin
              res[0] <= {3'b000, opcode[7], 4'h0};
              rlen   <= `FDCD_LEN_ONE;
              state  <= fdcd_pkg::ST_RESULT;
            end
            fdcd_pkg::C_INVALID: begin
              res[0] <= `FDCD_ST0_INVALID;
              rlen   <= `FDCD_LEN_ONE;
              state  <= fdcd_pkg::ST_RESULT;
            end
            fdcd_pkg::C_SPECIFY, fdcd_pkg::C_CONFIG, fdcd_pkg::C_PERP: begin
              state <= fdcd_pkg::ST_IDLE;
            end
            default: state <= fdcd_pkg::ST_IDLE;
          endcase
        end
        fdcd_pkg::ST_SEEK: begin
          // done once on target, no result phase
          if (cur_pcn == tgt) state <= fdcd_pkg::ST_IDLE;
        end
        fdcd_pkg::ST_RDID: begin
          // first ID with good CRC wins; bad ones skipped
          if (id_valid_i && id_crc_ok_i) begin
            res[0] <= {5'b00000, param[0][2:0]};
            res[1] <= 8'h00;
            res[2] <= 8'h00;
            res[3] <= id_field_i.cyl;
            res[4] <= id_field_i.head;
            res[5] <= id_field_i.rec;
            res[6] <= id_field_i.size;
            rlen   <= `FDCD_LEN_RDID;
            state  <= fdcd_pkg::ST_RESULT;
          end
        end
        fdcd_pkg::ST_RESULT: begin
          if (rd_data) begin
            ridx <= ridx + 4'h1;
            if (ridx == rlen - 4'h1) state <= fdcd_pkg::ST_IDLE;
          end
        end
        default: state <= fdcd_pkg::ST_IDLE;
      endcase
    end
  end

  // Configuration store, updated only at dispatch
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {step_rate_time, head_unload_time, head_load_time, nd} <= '0;
      {implied_seek_enable, poll, thr, precomp_start_track} <= '0;
      fifo_disable    <= `FDCD_RST_FIFO_DISABLE;
      perp_drv <= 4'h0;
      perp_gw  <= 2'b00;
      lock     <= 1'b0;
    end else if (state == fdcd_pkg::ST_DISPATCH) begin
      if (cls == fdcd_pkg::C_SPECIFY) begin
        {step_rate_time, head_unload_time} <= param[0];
        {head_load_time, nd}  <= param[1];
      end
      if (cls == fdcd_pkg::C_CONFIG) begin
        {implied_seek_enable, fifo_disable, poll, thr} <= param[1][6:0];
        precomp_start_track <= param[2];
      end
      if (cls == fdcd_pkg::C_PERP) begin
        // drive enables change only with override set
        if (param[0][7]) perp_drv <= param[0][5:2];
        perp_gw <= param[0][1:0];
      end
      if (cls == fdcd_pkg::C_LOCK) lock <= opcode[7];
    end
  end

  // Last transfer kind, reported back through the dump
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_fmt <= 1'b0;
      sc_val   <= 8'h00;
      eot_val  <= 8'h00;
    end else if (xfer_done_i) begin
      last_fmt <= xfer_format_i;
      if (xfer_format_i) sc_val <= xfer_count_i;
      else eot_val <= xfer_count_i;
    end
  end

  // Head stepper: one step per interval toward the target
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 4; i++) present_cylinder_number[i] <= 8'h00;
      tgt        <= 8'h00;
      sdrv       <= 2'b00;
      tmr        <= 24'h00_0000;
      step_o     <= 1'b0;
      step_dir_o <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (state == fdcd_pkg::ST_DISPATCH &&
          (cls == fdcd_pkg::C_SEEK || cls == fdcd_pkg::C_RSEEK)) begin
        // select bits pick an internal cylinder slot only
        sdrv <= param[0][1:0];
        tmr  <= 24'h00_0000;
        if (cls == fdcd_pkg::C_SEEK) tgt <= param[1];
        else if (opcode[6]) tgt <= present_cylinder_number[param[0][1:0]] + param[1];
        else tgt <= present_cylinder_number[param[0][1:0]] - param[1];
      end else if (state == fdcd_pkg::ST_SEEK && cur_pcn != tgt) begin
        if (tmr == 24'h00_0000) begin
          step_o     <= 1'b1;
          step_dir_o <= tgt > cur_pcn;
          present_cylinder_number[sdrv]  <= (tgt > cur_pcn) ? cur_pcn + 8'h01 : cur_pcn - 8'h01;
          tmr        <= step_len - 24'h00_0001;
        end else begin
          tmr <= tmr - 24'h00_0001;
        end
      end
    end
  end

  // Checks on the sequencer and stores
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_go(fdcd_pkg::fdcd_cmd_t c);
    state == fdcd_pkg::ST_DISPATCH && cls == c;
  endsequence

  a_invalid_code: assert property (s_go(fdcd_pkg::C_INVALID) |=>
    state == fdcd_pkg::ST_RESULT && res[0] == `FDCD_ST0_INVALID && rlen == `FDCD_LEN_ONE)
    else $error("invalid opcode result wrong");
  a_sense_byte: assert property (s_go(fdcd_pkg::C_SENSE) |=>
    rlen == `FDCD_LEN_ONE && res[0][2:0] == $past(param[0][2:0]))
    else $error("sense drive byte wrong");
  a_step_up: assert property (step_o && step_dir_o |->
    cur_pcn == $past(cur_pcn) + 8'h01)
    else $error("step did not advance cylinder");
  a_seek_done: assert property (state == fdcd_pkg::ST_SEEK && cur_pcn == tgt
    |=> state == fdcd_pkg::ST_IDLE && !step_o)
    else $error("seek did not end on target");
  a_rdid_capture: assert property (state == fdcd_pkg::ST_RDID && id_valid_i
    && id_crc_ok_i |=> state == fdcd_pkg::ST_RESULT && res[3] == $past(id_field_i.cyl))
    else $error("read id capture wrong");
  a_rdid_badcrc: assert property (state == fdcd_pkg::ST_RDID && !id_crc_ok_i
    |=> state == fdcd_pkg::ST_RDID)
    else $error("bad id accepted");
  a_perp_store: assert property (s_go(fdcd_pkg::C_PERP) |=>
    perp_gw == $past(param[0][1:0]))
    else $error("perpendicular bits not stored");
  a_specify_store: assert property (s_go(fdcd_pkg::C_SPECIFY) |=>
    step_rate_time == $past(param[0][7:4]) && nd == $past(param[1][0]))
    else $error("specify not stored");
  a_lock_result: assert property (s_go(fdcd_pkg::C_LOCK) |=>
    lock == $past(opcode[7]) && res[0] == {3'b000, lock, 4'h0})
    else $error("lock result wrong");
  a_dump_count: assert property (s_go(fdcd_pkg::C_DUMP) |=>
    res[6] == ($past(last_fmt) ? $past(sc_val) : $past(eot_val)))
    else $error("dump count wrong");

endmodule

/* File: tb/fdcd_drive_model.sv */
// Drive side: head position, ID fields from the data separator
module fdcd_drive_model (
  input  wire logic          clk_i,
  input  wire logic          sys_rst_i,
  input  wire logic          step_i,
  input  wire logic          step_dir_i,
  input  wire logic          id_go_i,
  input  fdcd_pkg::fdcd_id_t id_good_i,
  output fdcd_pkg::fdcd_id_t id_field_o,
  output logic               id_valid_o,
  output logic               id_crc_ok_o,
  output logic [7:0]         cyl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] id_cnt; // Cycles since the read request

  // Head follows every step pulse
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cyl_o <= 8'h00;
    end else if (step_i) begin
      cyl_o <= step_dir_i ? cyl_o + 8'h01 : cyl_o - 8'h01;
    end
  end

  // bad CRC field first
  // Outside a field the bus toggles, so a stale capture shows up
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      id_cnt      <= 5'h00;
      id_valid_o  <= 1'b0;
      id_crc_ok_o <= 1'b0;
      id_field_o  <= '0;
    end else begin
      id_cnt      <= id_go_i ? 5'h01 : ((id_cnt != 5'h00) ? id_cnt + 5'h01 : 5'h00);
      id_valid_o  <= (id_cnt == 5'h06) || (id_cnt == 5'h0C);
      id_crc_ok_o <= (id_cnt == 5'h0C);
      id_field_o  <= (id_cnt == 5'h0C) ? id_good_i : ~id_field_o;
    end
  end
endmodule

/* File: tb/fdcd_cmd_decoder_test.sv */
`include "fdcd_defs.svh"

// Host-side bench: bus master, expectation queue, read monitor
module fdcd_cmd_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk_i = 1'b0;
  logic               sys_rst_i = 1'b1;
  logic               wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]         wb_adr_i = 4'h0;
  logic [3:0]         wb_sel_i = 4'h0;  // Byte lanes, driven with each request
  logic [31:0]        wb_dat_i = 32'h0000_0000;
  logic [31:0]        wb_dat_o;
  logic               wb_ack_o, step_o, step_dir_o, id_valid, id_crc_ok;
  logic [2:0]         sense = 3'h0;  // {ready, track0, protect}
  fdcd_pkg::fdcd_id_t id_field, id_good = '0;
  logic               id_go = 1'b0, want = 1'b0;
  logic               xfer_done = 1'b0, xfer_fmt = 1'b0;
  logic [7:0]         xfer_cnt = 8'h00, cyl, pos = 8'h00, b, q;
  logic [2:0]         sel;           // Head and drive select
  logic [7:0]         dmp [10];      // Expected dump image
  logic [7:0]         expq [$];      // Expected read bytes
  logic [7:0]         inv [4] = '{8'h00, 8'h1F, 8'hFF, 8'h2B};
  int                 n_mismatch = 0;
  int                 total_checks = 0;

  always #2 clk_i = ~clk_i;

  fdcd_cmd_decoder #(.STEP_UNIT_CYC(4)) DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .drive_sense_i(sense), .id_field_i(id_field),
    .id_valid_i(id_valid), .id_crc_ok_i(id_crc_ok), .xfer_done_i(xfer_done),
    .xfer_format_i(xfer_fmt), .xfer_count_i(xfer_cnt), .step_o(step_o), .step_dir_o(step_dir_o));

  fdcd_drive_model drv (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .step_i(step_o), .step_dir_i(step_dir_o),
    .id_go_i(id_go), .id_good_i(id_good), .id_field_o(id_field), .id_valid_o(id_valid),
    .id_crc_ok_o(id_crc_ok), .cyl_o(cyl));

  task automatic close_out();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One classic cycle; held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic c);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h00_0000, d};
    want     <= c;
    // No cycle budget here: only the watchdog ends a stalled wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
    want     <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] d);
    bus(1'b1, `FDCD_ADR_DATA, d, 1'b0);
  endtask

  // Expectation noted before the request goes out
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    expq.push_back(e);
    bus(1'b0, a, 8'h00, 1'b1);
  endtask

  // Poll a status bit; a hang is left to the watchdog
  task automatic wait_st(input int bi, input logic v);
    repeat (2) @(posedge clk_i);
    do begin
      bus(1'b0, `FDCD_ADR_STAT, 8'h00, 1'b0);
    end while (q[bi] !== v);
  endtask

  task automatic dump_chk();
    wr(`FDCD_OP_DUMP);
    wait_st(1, 1'b1);
    for (int i = 0; i < 10; i++) begin
      rd(`FDCD_ADR_DATA, dmp[i]);
    end
  endtask

  // Seek and follow the head; select bits kept consistent by the host
  task automatic seek(input logic [7:0] op, input logic [1:0] d, input logic [7:0] n,
                      input logic [7:0] np);
    wr(op);
    wr({6'h00, d});
    wr(n);
    wait_st(2, 1'b0);
    pos = pos + np - dmp[d];
    dmp[d] = np;
    check({24'h00_0000, cyl}, {24'h00_0000, pos});
  endtask

  task automatic xfer(input logic f, input logic [7:0] c);
    @(posedge clk_i);
    xfer_done <= 1'b1;
    xfer_fmt  <= f;
    xfer_cnt  <= c;
    @(posedge clk_i);
    xfer_done <= 1'b0;
    dmp[6] = c;
  endtask

  // Monitor: oldest note against each checked read
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && want) begin
      check(wb_dat_o, {24'h00_0000, expq.pop_front()});
    end
  end

  // Watchdog
  initial begin
    repeat (30000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end

  initial begin
    void'($urandom(32'h8719));
    foreach (dmp[i]) dmp[i] = 8'h00;
    dmp[8] = 8'h20;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Idle data read and unmapped place both read zero
    rd(`FDCD_ADR_DATA, 8'h00);
    rd(4'h8, 8'h00);
    dump_chk();
    dmp[4] = {4'hE, 4'($urandom)};
    dmp[5] = {7'($urandom), 1'b0};
    wr(`FDCD_OP_SPECIFY);
    wr(dmp[4]);
    wr(dmp[5]);
    // Configure, then perpendicular with override set
    dmp[8] = {1'b0, 7'($urandom)};
    dmp[9] = 8'($urandom);
    wr(`FDCD_OP_CONFIG);
    wr(8'h00);
    wr(dmp[8]);
    wr(dmp[9]);
    b = {2'b10, 6'($urandom)};
    dmp[7][5:0] = b[5:0];
    wr(`FDCD_OP_PERP);
    wr(b);
    for (int l = 1; l >= 0; l--) begin
      wr({l[0], 7'h14});
      wait_st(1, 1'b1);
      rd(`FDCD_ADR_DATA, {3'h0, l[0], 4'h0});
      dmp[7][7] = l[0];
    end
    // Absolute seeks on two drives, then relative both ways
    b = 8'($urandom_range(12, 3));
    seek(`FDCD_OP_SEEK, 2'd0, b, b);
    b = 8'($urandom_range(12, 3));
    seek(`FDCD_OP_SEEK, 2'd2, b, b);
    seek(8'hCF, 2'd0, 8'h03, dmp[0] + 8'h03);
    seek(`FDCD_OP_RSEEK, 2'd2, 8'h02, dmp[2] - 8'h02);
    dump_chk();
    for (int h = 0; h < 2; h++) begin
      sense <= 3'($urandom);
      sel = {h[0], 2'($urandom)};
      wr(`FDCD_OP_SENSE);
      wr({5'h00, sel});
      wait_st(1, 1'b1);
      rd(`FDCD_ADR_DATA, {1'b0, sense[0], sense[2], sense[1], 1'b1, sel});
    end
    // read ID skips the bad-CRC field
    id_good <= 32'($urandom);
    wr(8'h4A);
    wr({5'h00, sel});
    @(posedge clk_i);
    id_go <= 1'b1;
    @(posedge clk_i);
    id_go <= 1'b0;
    wait_st(1, 1'b1);
    rd(`FDCD_ADR_DATA, {5'h00, sel});
    rd(`FDCD_ADR_DATA, 8'h00);
    rd(`FDCD_ADR_DATA, 8'h00);
    for (int i = 3; i >= 0; i--) begin
      rd(`FDCD_ADR_DATA, id_good[8*i +: 8]);
    end
    foreach (inv[i]) begin
      wr(inv[i]);
      wait_st(1, 1'b1);
      rd(`FDCD_ADR_DATA, `FDCD_ST0_INVALID);
    end
    // override clear: gap bits change, drive enables kept
    b = {2'b00, 6'($urandom)};
    dmp[7][1:0] = b[1:0];
    wr(`FDCD_OP_PERP);
    wr(b);
    // count after format, then after read
    xfer(1'b1, 8'($urandom));
    dump_chk();
    xfer(1'b0, 8'($urandom));
    dump_chk();
    close_out();
  end
endmodule
